// [include/qdr_pkg.sv]
package qdr_pkg;

  // read opcodes and the mode reset opcode
  localparam logic [7:0] OP_QUAD_3B    = 8'h6b;
  localparam logic [7:0] OP_QUAD_4B    = 8'h6c;
  localparam logic [7:0] OP_DUAL_3B    = 8'hbb;
  localparam logic [7:0] OP_DUAL_4B    = 8'hbc;
  localparam logic [7:0] OP_MODE_RESET = 8'hff;

  // mode byte upper nibble that keeps continuous read
  localparam logic [3:0] MODE_CONT = 4'ha;

  // address lengths in bits and phase counter end values
  localparam logic [5:0] ALEN_3B   = 6'h18;
  localparam logic [5:0] ALEN_4B   = 6'h20;
  localparam logic [5:0] CMD_LAST  = 6'h07;
  localparam logic [5:0] MODE_LAST = 6'h03;
  localparam logic [5:0] MODE_DRV  = 6'h02;

  // serial clock made by the host end
  localparam int SCK_PERIOD_NS  = 160;
  localparam int CORE_PERIOD_NS = 10;
  localparam int SCK_HALF_CYC   = SCK_PERIOD_NS / (2 * CORE_PERIOD_NS);

  // protocol phases, shared by both ends
  typedef enum logic [2:0] {
    QDR_IDLE,
    QDR_CMD,
    QDR_ADDR,
    QDR_MODE,
    QDR_DUMMY,
    QDR_DATA,
    QDR_END
  } qdr_state_e;

  // address length for a read opcode and the address length bit
  function automatic logic [5:0] qdr_addr_bits(input logic alb, input logic [7:0] op);
    if (op == OP_QUAD_4B || op == OP_DUAL_4B)
      return ALEN_4B;
    return alb ? ALEN_4B : ALEN_3B;
  endfunction : qdr_addr_bits

endpackage : qdr_pkg

// [include/qdr_if.sv]
`timescale 1ns/10ps
interface qdr_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] f_io_o;
  logic [3:0] f_io_oe;
  logic [3:0] io;

  // resolved line level, weak pull-up when nobody drives
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_line
      assign io[i] = f_io_oe[i] ? f_io_o[i] : (h_io_oe[i] ? h_io_o[i] : 1'b1);
    end
  endgenerate

  modport host (output cs_n, output sck, output h_io_o, output h_io_oe, input io);
  modport flash (input cs_n, input sck, input io, output f_io_o, output f_io_oe);
endinterface : qdr_if

// [verilog/qdr_sync.sv]
`timescale 1ns/10ps
module qdr_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // two flops; only the second stage is read by logic
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta <= INIT;
      q    <= INIT;
    end
    else if (clk_en)
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : qdr_sync

// [verilog/qdr_flash_end.sv]
// Notes on behaviour
// R1: 6Bh/BBh take 3 or 4 address bytes
// R2: 6Ch always takes a 4-byte address
// R3: quad read inserts latency-code dummy cycles
// R4: dummy cycle line values are ignored
// R5: quad data one nibble per falling edge
// R6: address increments per byte, wraps to zero
// R7: quad command and address on line 0
// R8: BCh always takes a 4-byte address
// R9: dual address two bits per rising edge
// R10: dual: instruction, address, four mode, latency
// R11: mode Axh keeps continuous read, no instruction
// R12: only mode upper nibble decides continuation
// R13: other mode leaves continuous read at deselect
// R14: mode reset command leaves continuous read
// R15: dual read adds latency-code dummy cycles
// R16: host releases lines by first data fall
// R17: dual data two bits per falling edge
// R18: host keeps select low through mode, dummy
// R19: address most significant bit first
// R20: address length bit widens legacy opcodes
// R21: instruction one bit per rising edge
// R22: deselect ends the read, outputs stop
// R23: bytes go high bits first, fixed lanes
// R24: lines released while select is high
`timescale 1ns/10ps
module qdr_flash_end
#(
  parameter int AW = 25
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  qdr_if.flash               link,
  input  wire logic          address_length_bit,
  input  wire logic [3:0]    latency_code_field,
  input  wire logic [7:0]    mem_data,
  output logic      [AW-1:0] mem_addr,
  output logic               cont_mode
);
  import qdr_pkg::*;

  if (AW < 1 || AW > 32)
  begin : g_bad_aw
    $error("qdr_flash_end: AW must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and clock edge finding

  logic [5:0] pins_s;
  logic [3:0] io_s;
  logic       cs_s, sck_s, sck_q, rise, fall;

  qdr_sync #(
    .W    (6),
    .INIT (6'h20)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .d        ({link.cs_n, link.sck, link.io}),
    .q        (pins_s)
  );

  // split synchronised pins, detect serial clock edges
  assign {cs_s, sck_s, io_s} = pins_s;
  assign rise  = sck_s & ~sck_q;
  assign fall  = ~sck_s & sck_q;

  ////////////////////////////////////////////////////////////////////////////
  // protocol state

  qdr_state_e    state, next_state;
  logic [5:0]    cnt, next_cnt;
  logic [5:0]    alen, next_alen;
  logic [31:0]   sh, next_sh;
  logic          is_dual, next_is_dual;
  logic          mode_ok, next_mode_ok;
  logic          dual_seen, next_dual_seen;
  logic          next_cont_mode;
  logic [AW-1:0] next_mem_addr;
  logic [7:0]    byte_sr, next_byte_sr;
  logic [1:0]    unit, next_unit;
  logic [3:0]    dummy, next_dummy;
  logic [3:0]    io_o, next_io_o;
  logic [3:0]    io_oe, next_io_oe;

  // next values of the read sequencer
  always_comb
  begin : p_next
    logic [7:0] op;
    logic [7:0] b;
    logic       drive;
    op             = {sh[6:0], io_s[0]};
    b              = byte_sr;
    drive          = 1'b0;
    next_state     = state;
    next_cnt       = cnt;
    next_alen      = alen;
    next_sh        = sh;
    next_is_dual   = is_dual;
    next_mode_ok   = mode_ok;
    next_dual_seen = dual_seen;
    next_cont_mode = cont_mode;
    next_mem_addr  = mem_addr;
    next_byte_sr   = byte_sr;
    next_unit      = unit;
    next_dummy     = dummy;
    next_io_o      = io_o;
    next_io_oe     = io_oe;
    if (cs_s)
    begin
      next_state = QDR_IDLE;
      next_io_oe = 4'h0; // R22 R24
      if (dual_seen)
      begin
        next_cont_mode = mode_ok; // R11 R13
        next_dual_seen = 1'b0;
      end
    end
    else
    begin
      case (state)
        QDR_IDLE:
        begin
          next_cnt = '0;
          next_sh  = '0;
          if (cont_mode)
          begin
            next_state     = QDR_ADDR; // R11
            next_is_dual   = 1'b1;
            next_mode_ok   = 1'b0; // R14
            next_dual_seen = 1'b1;
          end
          else
            next_state = QDR_CMD;
        end
        QDR_CMD:
          if (rise)
          begin
            next_sh  = {sh[30:0], io_s[0]}; // R21 R7
            next_cnt = cnt + 6'h01;
            if (cnt == CMD_LAST)
            begin
              next_cnt  = '0;
              next_sh   = '0;
              next_alen = qdr_addr_bits(address_length_bit, op); // R1 R2 R8 R20
              case (op)
                OP_QUAD_3B, OP_QUAD_4B:
                begin
                  next_state   = QDR_ADDR;
                  next_is_dual = 1'b0;
                end
                OP_DUAL_3B, OP_DUAL_4B:
                begin
                  next_state     = QDR_ADDR; // R10
                  next_is_dual   = 1'b1;
                  next_mode_ok   = 1'b0;
                  next_dual_seen = 1'b1;
                end
                OP_MODE_RESET:
                begin
                  next_cont_mode = 1'b0; // R14
                  next_state     = QDR_END;
                end
                default:
                  next_state = QDR_END;
              endcase
            end
          end
        QDR_ADDR:
          if (rise)
          begin
            next_sh  = is_dual ? {sh[29:0], io_s[1:0]} : {sh[30:0], io_s[0]}; // R7 R9 R19 R23
            next_cnt = cnt + (is_dual ? 6'h02 : 6'h01);
            if (next_cnt == alen)
            begin
              next_mem_addr = next_sh[AW-1:0]; // R6
              next_sh       = '0;
              next_cnt      = '0;
              next_unit     = 2'h0;
              next_dummy    = latency_code_field; // R3 R15
              next_state    = is_dual ? QDR_MODE : QDR_DUMMY;
            end
          end
        QDR_MODE:
          if (rise)
          begin
            next_sh  = {sh[29:0], io_s[1], io_s[0]};
            next_cnt = cnt + 6'h01;
            if (cnt == MODE_LAST)
            begin
              next_mode_ok = (next_sh[7:4] == MODE_CONT); // R12
              next_cnt     = '0;
              next_state   = QDR_DUMMY;
            end
          end
        QDR_DUMMY:
          if (fall)
          begin
            // line values are never looked at here
            if (dummy == 4'h0)
            begin
              drive      = 1'b1; // R4
              next_state = QDR_DATA;
            end
            else
              next_dummy = dummy - 4'h1;
          end
        QDR_DATA:
          drive = fall;
        default:
          next_state = state;
      endcase
      // put out the next unit of the current byte
      if (drive)
      begin
        if (unit == 2'h0)
        begin
          b             = mem_data;
          next_mem_addr = mem_addr + 1'b1; // R6
        end
        next_io_o    = is_dual ? {2'h0, b[7:6]} : b[7:4]; // R5 R17 R23
        next_io_oe   = is_dual ? 4'h3 : 4'hf;
        next_byte_sr = is_dual ? {b[5:0], 2'h0} : {b[3:0], 4'h0};
        next_unit    = (is_dual || unit == 2'h0) ? unit + 2'h1 : 2'h0;
      end
    end
  end

  // register the sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst) // shift, count and length registers are loaded before use
    begin
      state     <= QDR_IDLE;
      mode_ok   <= 1'b0;
      dual_seen <= 1'b0;
      cont_mode <= 1'b0;
      mem_addr  <= '0;
      unit      <= 2'h0;
      io_o      <= 4'h0;
      io_oe     <= 4'h0;
      sck_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      alen      <= next_alen;
      sh        <= next_sh;
      is_dual   <= next_is_dual;
      mode_ok   <= next_mode_ok;
      dual_seen <= next_dual_seen;
      cont_mode <= next_cont_mode;
      mem_addr  <= next_mem_addr;
      byte_sr   <= next_byte_sr;
      unit      <= next_unit;
      dummy     <= next_dummy;
      io_o      <= next_io_o;
      io_oe     <= next_io_oe;
      sck_q     <= sck_s;
    end
  end

  // line drivers straight from flops
  assign link.f_io_o  = io_o;
  assign link.f_io_oe = io_oe;
endmodule : qdr_flash_end

// [verilog/qdr_host_end.sv]
`timescale 1ns/10ps
module qdr_host_end
  import qdr_pkg::*;
#(
  parameter int HALF = qdr_pkg::SCK_HALF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  qdr_if.host              link,
  input  wire logic        start,
  input  wire logic        send_cmd,
  input  wire logic [7:0]  cmd,
  input  wire logic        use_dual,
  input  wire logic        addr_4b,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  mode_byte,
  input  wire logic [3:0]  dummy_cycles,
  input  wire logic [15:0] byte_count,
  output logic             busy,
  output logic             rd_valid,
  output logic      [7:0]  rd_data
);
  import qdr_pkg::*;

  if (HALF < 4 || HALF > 255)
  begin : g_bad_half
    $error("qdr_host_end: HALF must be 4 to 255");
  end

  localparam logic [7:0] DIV_LAST = 8'(HALF - 1);

  logic [3:0] io_s;

  qdr_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .d        (link.io),
    .q        (io_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  qdr_state_e  state;
  qdr_state_e  next_state;
  logic [7:0]  div;
  logic [7:0]  next_div;
  logic        sck;
  logic        next_sck;
  logic        cs_n;
  logic        next_cs_n;
  logic [5:0]  cnt;
  logic [5:0]  next_cnt;
  logic [31:0] sh;
  logic [31:0] next_sh;
  logic [31:0] addr_hold;
  logic [31:0] next_addr_hold;
  logic        dual;
  logic        next_dual;
  logic        is_reset;
  logic        next_is_reset;
  logic [5:0]  alen;
  logic [5:0]  next_alen;
  logic [7:0]  mode;
  logic [7:0]  next_mode;
  logic [3:0]  dummy;
  logic [3:0]  next_dummy;
  logic [15:0] left;
  logic [15:0] next_left;
  logic [7:0]  rx;
  logic [7:0]  next_rx;
  logic [1:0]  unit;
  logic [1:0]  next_unit;
  logic        next_busy;
  logic        next_rd_valid;
  logic [7:0]  next_rd_data;
  logic [3:0]  io_o;
  logic [3:0]  next_io_o;
  logic [3:0]  io_oe;
  logic [3:0]  next_io_oe;

  // next values: clock divider, phases, line drive and capture
  always_comb
  begin : p_next
    logic tick;
    logic hfall;
    logic hrise;
    tick           = (div == DIV_LAST);
    hfall          = tick & sck;
    hrise          = tick & ~sck;
    next_state     = state;
    next_div       = (state == QDR_IDLE) ? 8'h00 : (tick ? 8'h00 : div + 8'h01);
    next_sck       = (state == QDR_IDLE || state == QDR_END) ? 1'b0 : (tick ? ~sck : sck);
    next_cs_n      = cs_n;
    next_cnt       = cnt;
    next_sh        = sh;
    next_addr_hold = addr_hold;
    next_dual      = dual;
    next_is_reset  = is_reset;
    next_alen      = alen;
    next_mode      = mode;
    next_dummy     = dummy;
    next_left      = left;
    next_rx        = rx;
    next_unit      = unit;
    next_busy      = busy;
    next_rd_valid  = 1'b0;
    next_rd_data   = rd_data;
    case (state)
      QDR_IDLE:
        if (start)
        begin
          next_dual      = use_dual;
          next_alen      = addr_4b ? ALEN_4B : ALEN_3B;
          next_addr_hold = addr_4b ? addr : {addr[23:0], 8'h00}; // R19
          next_mode      = mode_byte;
          next_dummy     = dummy_cycles;
          next_left      = byte_count;
          next_is_reset  = send_cmd && (cmd == OP_MODE_RESET);
          next_cs_n      = 1'b0;
          next_busy      = 1'b1;
          next_cnt       = '0;
          next_unit      = 2'h0;
          next_state     = send_cmd ? QDR_CMD : QDR_ADDR;
          next_sh        = send_cmd ? {cmd, 24'h000000} : next_addr_hold;
        end
      QDR_CMD:
        if (hfall)
        begin
          next_sh  = {sh[30:0], 1'b0};
          next_cnt = cnt + 6'h01;
          if (cnt == CMD_LAST)
          begin
            next_cnt   = '0;
            next_sh    = addr_hold;
            next_state = is_reset ? QDR_END : QDR_ADDR; // R10
          end
        end
      QDR_ADDR:
        if (hfall)
        begin
          next_sh  = dual ? {sh[29:0], 2'h0} : {sh[30:0], 1'b0};
          next_cnt = cnt + (dual ? 6'h02 : 6'h01);
          if (next_cnt == alen)
          begin
            next_cnt   = '0;
            next_sh    = {mode, 24'h000000};
            next_state = dual ? QDR_MODE : ((dummy == 4'h0) ? QDR_DATA : QDR_DUMMY);
          end
        end
      QDR_MODE:
        if (hfall)
        begin
          next_sh  = {sh[29:0], 2'h0};
          next_cnt = cnt + 6'h01;
          if (cnt == MODE_LAST)
          begin
            next_cnt   = '0;
            next_state = (dummy == 4'h0) ? QDR_DATA : QDR_DUMMY; // R18
          end
        end
      QDR_DUMMY:
        if (hfall)
        begin
          next_cnt = cnt + 6'h01;
          if (next_cnt == {2'h0, dummy})
          begin
            next_cnt   = '0;
            next_state = QDR_DATA;
          end
        end
      QDR_DATA:
        if (hrise && left != 16'h0000)
        begin
          next_rx   = dual ? {rx[5:0], io_s[1:0]} : {rx[3:0], io_s}; // R23
          next_unit = unit + 2'h1;
          if ((dual && unit == 2'h3) || (!dual && unit == 2'h1))
          begin
            next_unit     = 2'h0;
            next_rd_valid = 1'b1;
            next_rd_data  = next_rx;
            next_left     = left - 16'h0001;
          end
        end
        else if (hfall && left == 16'h0000)
        begin
          next_cs_n  = 1'b1; // R22
          next_state = QDR_END;
        end
      QDR_END:
      begin
        next_cs_n = 1'b1;
        if (tick)
        begin
          next_busy  = 1'b0;
          next_state = QDR_IDLE;
        end
      end
      default:
        next_state = QDR_IDLE;
    endcase
    // drive only instruction, address and upper mode nibble
    next_io_o  = 4'h0;
    next_io_oe = 4'h0;
    case (next_state)
      QDR_CMD:
      begin
        next_io_o  = {3'h0, next_sh[31]};
        next_io_oe = 4'h1;
      end
      QDR_ADDR:
      begin
        next_io_o  = next_dual ? {2'h0, next_sh[31:30]} : {3'h0, next_sh[31]};
        next_io_oe = next_dual ? 4'h3 : 4'h1;
      end
      QDR_MODE:
        if (next_cnt < MODE_DRV)
        begin
          next_io_o  = {2'h0, next_sh[31:30]};
          next_io_oe = 4'h3; // R12 R16
        end
      default:
        next_io_oe = 4'h0; // R4 R16
    endcase
  end

  // register the sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state     <= QDR_IDLE;
      div       <= 8'h00;
      sck       <= 1'b0;
      cs_n      <= 1'b1;
      cnt       <= '0;
      sh        <= '0;
      addr_hold <= '0;
      dual      <= 1'b0;
      is_reset  <= 1'b0;
      alen      <= ALEN_3B;
      mode      <= 8'h00;
      dummy     <= 4'h0;
      left      <= 16'h0000;
      rx        <= 8'h00;
      unit      <= 2'h0;
      busy      <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
      io_o      <= 4'h0;
      io_oe     <= 4'h0;
    end
    else if (clk_en)
    begin
      state     <= next_state;
      div       <= next_div;
      sck       <= next_sck;
      cs_n      <= next_cs_n;
      cnt       <= next_cnt;
      sh        <= next_sh;
      addr_hold <= next_addr_hold;
      dual      <= next_dual;
      is_reset  <= next_is_reset;
      alen      <= next_alen;
      mode      <= next_mode;
      dummy     <= next_dummy;
      left      <= next_left;
      rx        <= next_rx;
      unit      <= next_unit;
      busy      <= next_busy;
      rd_valid  <= next_rd_valid;
      rd_data   <= next_rd_data;
      io_o      <= next_io_o;
      io_oe     <= next_io_oe;
    end
  end

  // link pins straight from flops
  assign link.cs_n    = cs_n;
  assign link.sck     = sck;
  assign link.h_io_o  = io_o;
  assign link.h_io_oe = io_oe;
endmodule : qdr_host_end

// [test/qdr_sva.sv]
`timescale 1ns/10ps
module qdr_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] f_io_o,
  input wire logic [3:0] f_io_oe
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////
  // link relations seen on the wires
  sck_idle_a:
  assert property (cs_n |-> !sck) else $error("sck not idle while deselected");
  no_clash_a:
  assert property ((f_io_oe & h_io_oe) == 4'h0) else $error("both ends drive one line");
  flash_release_a:
  assert property ($rose(cs_n) |-> ##[1:5] f_io_oe == 4'h0) else $error("flash kept driving");
  desel_quiet_a:
  assert property (cs_n [*6] |-> f_io_oe == 4'h0) else $error("flash drives while deselected");
  data_hold_a:
  assert property ($rose(sck) |-> $stable(f_io_o) [*4]) else $error("data moved near rise");
  lane_set_a:
  assert property (f_io_oe inside {4'h0, 4'h3, 4'hf}) else $error("bad flash lane set");
  drive_start_a:
  assert property ($rose(|f_io_oe) |-> !cs_n && !sck && h_io_oe == 4'h0)
    else $error("flash drive starts at a wrong point");
  host_bit_a:
  assert property ($changed(h_io_o) && $past(h_io_oe) != 4'h0 && h_io_oe != 4'h0 |-> $fell(sck))
    else $error("host bit moved off a falling edge");
  sck_high_a:
  assert property ($rose(sck) |-> sck [*8] ##1 !sck) else $error("sck high time wrong");
endmodule : qdr_sva

// [test/qdr_test.sv]
`timescale 1ns/10ps
module qdr_test;
  import qdr_pkg::*;

  logic        core_clk;
  logic        rst                = 1'b1;
  logic        start              = 1'b0;
  logic        send_cmd           = 1'b0;
  logic [7:0]  cmd                = 8'h00;
  logic        use_dual           = 1'b0;
  logic        addr_4b            = 1'b0;
  logic [31:0] addr               = 32'h0;
  logic [7:0]  mode_byte          = 8'h00;
  logic [3:0]  dummy_cycles       = 4'h0;
  logic [15:0] byte_count         = 16'h0;
  logic        address_length_bit = 1'b0;
  logic [3:0]  latency_code_field = 4'h0;
  logic        busy;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic [7:0]  mem_data;
  logic [7:0]  mem_addr;
  logic        cont_mode;
  logic [7:0]  rx[$];
  int          n_mismatch         = 0;
  int          checks_done        = 0;

  qdr_if link_if();

  ////////////////////////////////
  // 100 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // memory contents follow the address
  assign mem_data = mem_addr ^ 8'h3c;

  qdr_host_end i_qdr_host_end (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .link(link_if.host), .start(start), .send_cmd(send_cmd), .cmd(cmd), .use_dual(use_dual),
    .addr_4b(addr_4b), .addr(addr), .mode_byte(mode_byte), .dummy_cycles(dummy_cycles),
    .byte_count(byte_count), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data));

  qdr_flash_end #(.AW(8)) i_qdr_flash_end (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .link(link_if.flash), .address_length_bit(address_length_bit),
    .latency_code_field(latency_code_field), .mem_data(mem_data), .mem_addr(mem_addr),
    .cont_mode(cont_mode));

  qdr_sva i_qdr_sva (.core_clk(core_clk), .rst(rst), .cs_n(link_if.cs_n), .sck(link_if.sck),
    .h_io_o(link_if.h_io_o), .h_io_oe(link_if.h_io_oe), .f_io_o(link_if.f_io_o),
    .f_io_oe(link_if.f_io_oe));

  // collect received bytes away from the launching edge
  always @(negedge core_clk)
  begin
    if (rd_valid === 1'b1)
      rx.push_back(rd_data);
  end

  ////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // one read through the host end, then compare bytes and mode flag
  task automatic rd(input logic sc, input logic [7:0] op, input logic du, input logic a4,
                    input logic [31:0] ad, input logic [7:0] md, input logic [3:0] lt,
                    input int n, input logic cm);
    int k;
    rx.delete();
    @(negedge core_clk);
    send_cmd = sc;
    cmd = op;
    use_dual = du;
    addr_4b = a4;
    addr = ad;
    mode_byte = md;
    dummy_cycles = lt;
    latency_code_field = lt;
    byte_count = n[15:0];
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 5000)
    begin
      @(negedge core_clk);
      k++;
    end
    chk("busy", 32'h0, {31'h0, busy});
    chk("byte count", n, rx.size());
    for (int i = 0; i < n && i < rx.size(); i++)
      chk("rd_data", {24'h0, (ad[7:0] + i[7:0]) ^ 8'h3c}, {24'h0, rx[i]});
    chk("cont_mode", {31'h0, cm}, {31'h0, cont_mode});
  endtask : rd

  ////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    rd(1'b1, OP_QUAD_3B, 1'b0, 1'b0, 32'h0012_3456, 8'h00, 4'h0, 2, 1'b0);
    rd(1'b1, OP_QUAD_4B, 1'b0, 1'b1, 32'h9a00_bc77, 8'h00, 4'h3, 3, 1'b0);
    address_length_bit = 1'b1;
    rd(1'b1, OP_QUAD_3B, 1'b0, 1'b1, 32'h1122_3344, 8'h00, 4'hf, 1, 1'b0);
    rd(1'b1, OP_DUAL_3B, 1'b1, 1'b1, 32'h0708_09c1, 8'h3f, 4'h1, 2, 1'b0);
    address_length_bit = 1'b0;
    rd(1'b1, OP_QUAD_3B, 1'b0, 1'b0, 32'h0000_fffe, 8'h00, 4'h2, 3, 1'b0);
    rd(1'b1, OP_DUAL_3B, 1'b1, 1'b0, 32'h00ab_cd5a, 8'ha0, 4'h2, 2, 1'b1);
    rd(1'b0, 8'h00, 1'b1, 1'b0, 32'h00ff_0781, 8'h50, 4'h1, 2, 1'b0);
    rd(1'b1, OP_DUAL_4B, 1'b1, 1'b1, 32'h5500_aaff, 8'ha5, 4'h0, 2, 1'b1);
    rd(1'b1, OP_MODE_RESET, 1'b0, 1'b0, 32'h0, 8'h00, 4'h0, 0, 1'b0);
    rd(1'b1, OP_QUAD_4B, 1'b0, 1'b1, 32'h0000_0010, 8'h00, 4'h1, 1, 1'b0);
    rd(1'b1, 8'h03, 1'b0, 1'b0, 32'h0000_0042, 8'h00, 4'h0, 0, 1'b0);
    chk("mem_addr", 32'h11, {24'h0, mem_addr});
    stop_test();
  end

  // cut a hang short
  initial
  begin
    #500000;
    n_mismatch++;
    stop_test();
  end
endmodule : qdr_test
